// file: src/tscr_pkg.sv
`default_nettype none
package tscr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TMR0_COUNT = 8'h04;
  localparam logic [7:0] OFS_TMR1_COUNT = 8'h08;
  localparam logic [7:0] OFS_TMR2_COUNT = 8'h0c;
  localparam logic [7:0] OFS_CAP_RELOAD = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // control register layout
  localparam int CTRL_W = 17;
  localparam int CB_TMR0_MODE = 0;
  localparam int CB_TMR0_COUNTER = 2;
  localparam int CB_TMR0_GATE = 3;
  localparam int CB_TMR1_MODE = 4;
  localparam int CB_TMR1_COUNTER = 6;
  localparam int CB_TMR1_GATE = 7;
  localparam int CB_TMR0_RUN = 8;
  localparam int CB_TMR1_RUN = 9;
  localparam int CB_CAP_RELOAD_SEL = 10;
  localparam int CB_TMR2_COUNTER = 11;
  localparam int CB_TMR2_RUN = 12;
  localparam int CB_EXT_TRIG_EN = 13;
  localparam int CB_XMIT_CLK_SEL = 14;
  localparam int CB_RECV_CLK_SEL = 15;
  localparam int CB_CLK_OUT_EN = 16;

  // interrupt status and mask layout
  localparam int IRQ_W = 4;
  localparam int SB_TMR0_OVF = 0;
  localparam int SB_TMR1_OVF = 1;
  localparam int SB_TMR2_OVF = 2;
  localparam int SB_EXT_TRIG = 3;

  // timer zero / one modes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_AUTO8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    T2M_CAPTURE = 2'b00,
    T2M_RELOAD = 2'b01,
    T2M_BAUD = 2'b10,
    T2M_OTHER = 2'b11
  } tscr_t2mode_e;

  typedef enum logic [2:0] {
    REG_CONTROL = 3'b000,
    REG_TMR0_COUNT = 3'b001,
    REG_TMR1_COUNT = 3'b010,
    REG_TMR2_COUNT = 3'b011,
    REG_CAP_RELOAD = 3'b100,
    REG_IRQ_STATUS = 3'b101,
    REG_IRQ_MASK = 3'b110,
    REG_NONE = 3'b111
  } tscr_reg_e;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] rcap;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [3:0] pin_q;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic irq;
    logic baud_tick;
  } tscr_state_s;

  localparam tscr_state_s STATE_RESET = '0;

endpackage : tscr_pkg
`default_nettype wire

// file: src/tscr_top.sv
`timescale 1ns/10ps
`default_nettype none
module tscr_top
  import tscr_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // axi4-lite write address and data
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // external pins
  input wire logic EXT_IRQ_PIN_ZERO,
  input wire logic EXT_IRQ_PIN_ONE,
  input wire logic TMR_ZERO_COUNT_PIN,
  input wire logic TMR_ONE_COUNT_PIN,
  input wire logic TMR_TWO_COUNT_PIN,
  input wire logic TMR_TWO_TRIGGER_PIN,
  // outputs
  output logic IRQ,
  output logic TMR_ONE_BAUD_TICK
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic tscr_reg_e decode(input logic [7:0] addr);
    case (addr)
      OFS_CONTROL: decode = REG_CONTROL;
      OFS_TMR0_COUNT: decode = REG_TMR0_COUNT;
      OFS_TMR1_COUNT: decode = REG_TMR1_COUNT;
      OFS_TMR2_COUNT: decode = REG_TMR2_COUNT;
      OFS_CAP_RELOAD: decode = REG_CAP_RELOAD;
      OFS_IRQ_STATUS: decode = REG_IRQ_STATUS;
      OFS_IRQ_MASK: decode = REG_IRQ_MASK;
      default: decode = REG_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] read_word(input tscr_reg_e sel, input tscr_state_s s);
    case (sel)
      REG_CONTROL: read_word = {{(32-CTRL_W){1'b0}}, s.ctrl};
      REG_TMR0_COUNT: read_word = {16'h0000, s.cnt0};
      REG_TMR1_COUNT: read_word = {16'h0000, s.cnt1};
      REG_TMR2_COUNT: read_word = {16'h0000, s.cnt2};
      REG_CAP_RELOAD: read_word = {16'h0000, s.rcap};
      REG_IRQ_STATUS: read_word = {{(32-IRQ_W){1'b0}}, s.status};
      REG_IRQ_MASK: read_word = {{(32-IRQ_W){1'b0}}, s.mask};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction : merge

  // one counting step of timer zero or one in modes 0..2; bit 16 is the overflow
  function automatic logic [16:0] step(input logic [1:0] mode, input logic [15:0] c);
    case (mode)
      MODE_13BIT: step = (c[4:0] == 5'h1f) ? {c[15:8] == 8'hff, c[15:8] + 8'h01, c[7:5], 5'h00}
        : {1'b0, c[15:5], c[4:0] + 5'h01};
      MODE_16BIT: step = {c == 16'hffff, c + 16'h0001};
      MODE_AUTO8: step = (c[7:0] == 8'hff) ? {1'b1, c[15:8], c[15:8]}
        : {1'b0, c[15:8], c[7:0] + 8'h01};
      default: step = {1'b0, c};
    endcase
  endfunction : step

  ////////////////////////////////////////////////////////////////////////////////
  // datapath terms

  tscr_state_s st, nx;
  tscr_reg_e wr_sel, rd_sel;
  tscr_t2mode_e t2_mode;
  logic [3:0] pins, fall;
  logic [16:0] step0, step1;
  logic [IRQ_W-1:0] set;
  logic [31:0] wr_merged;
  logic split, tick0, hi_tick, tick1, tick2, trig, wr_fire, rd_fire;
  logic wr_cnt0, wr_cnt1, wr_cnt2, wr_rcap;

  assign pins = {TMR_TWO_TRIGGER_PIN, TMR_TWO_COUNT_PIN, TMR_ONE_COUNT_PIN, TMR_ZERO_COUNT_PIN};
  // previous sample against current: one pulse per falling edge
  assign fall = st.pin_q & ~pins;

  assign split = st.ctrl[CB_TMR0_MODE +: 2] == MODE_SPLIT;
  assign tick0 = st.ctrl[CB_TMR0_RUN] & (~st.ctrl[CB_TMR0_GATE] | EXT_IRQ_PIN_ZERO)
                 & (st.ctrl[CB_TMR0_COUNTER] ? fall[0] : 1'b1);
  assign hi_tick = split & st.ctrl[CB_TMR1_RUN];
  // a split timer zero takes over the run bit, so timer one then runs out of mode 3 whenever its gate allows
  assign tick1 = (split | st.ctrl[CB_TMR1_RUN]) & (~st.ctrl[CB_TMR1_GATE] | EXT_IRQ_PIN_ONE)
                 & (st.ctrl[CB_TMR1_MODE +: 2] != MODE_SPLIT)
                 & (st.ctrl[CB_TMR1_COUNTER] ? fall[1] : 1'b1);
  assign tick2 = st.ctrl[CB_TMR2_RUN] & (st.ctrl[CB_TMR2_COUNTER] ? fall[2] : 1'b1);
  assign trig = fall[3] & st.ctrl[CB_EXT_TRIG_EN];

  assign t2_mode = (st.ctrl[CB_XMIT_CLK_SEL] | st.ctrl[CB_RECV_CLK_SEL]) ? T2M_BAUD :
                   st.ctrl[CB_CAP_RELOAD_SEL] ? T2M_CAPTURE :
                   st.ctrl[CB_CLK_OUT_EN] ? T2M_OTHER : T2M_RELOAD;

  assign step0 = step(st.ctrl[CB_TMR0_MODE +: 2], st.cnt0);
  assign step1 = step(st.ctrl[CB_TMR1_MODE +: 2], st.cnt1);

  assign wr_fire = st.aw_got & st.w_got & ~st.bvalid;
  assign wr_sel = decode(st.awaddr);
  assign rd_fire = S_AXI_ARVALID & st.arready;
  assign rd_sel = decode(S_AXI_ARADDR);
  assign wr_merged = merge(read_word(wr_sel, st), st.wdata, st.wstrb);
  assign wr_cnt0 = wr_fire && wr_sel == REG_TMR0_COUNT;
  assign wr_cnt1 = wr_fire && wr_sel == REG_TMR1_COUNT;
  assign wr_cnt2 = wr_fire && wr_sel == REG_TMR2_COUNT;
  assign wr_rcap = wr_fire && wr_sel == REG_CAP_RELOAD;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nx = st;
    set = '0;
    // timer zero
    if (split) begin
      if (tick0) begin
        nx.cnt0[7:0] = st.cnt0[7:0] + 8'h01;
        set[SB_TMR0_OVF] = st.cnt0[7:0] == 8'hff;
      end
      if (hi_tick) begin
        nx.cnt0[15:8] = st.cnt0[15:8] + 8'h01;
        set[SB_TMR1_OVF] = st.cnt0[15:8] == 8'hff;
      end
    end else if (tick0) begin
      nx.cnt0 = step0[15:0];
      set[SB_TMR0_OVF] = step0[16];
    end
    // timer one; its flag belongs to the high byte while zero is split
    if (tick1) begin
      nx.cnt1 = step1[15:0];
      if (!split) begin
        set[SB_TMR1_OVF] = set[SB_TMR1_OVF] | step1[16];
      end
    end
    nx.baud_tick = tick1 & step1[16];
    // timer two counting
    if (tick2) begin
      if (st.cnt2 == 16'hffff) begin
        nx.cnt2 = (t2_mode == T2M_RELOAD || t2_mode == T2M_BAUD) ? st.rcap : 16'h0000;
        set[SB_TMR2_OVF] = t2_mode == T2M_CAPTURE || t2_mode == T2M_RELOAD;
      end else begin
        nx.cnt2 = st.cnt2 + 16'h0001;
      end
    end
    // timer two trigger; flag shares the interrupt with overflow
    if (trig) begin
      case (t2_mode)
        T2M_CAPTURE: begin
          nx.rcap = st.cnt2;
          set[SB_EXT_TRIG] = 1'b1;
        end
        T2M_RELOAD: begin
          nx.cnt2 = st.rcap;
          set[SB_EXT_TRIG] = 1'b1;
        end
        default: begin
          set[SB_EXT_TRIG] = 1'b1;
        end
      endcase
    end
    // status: read clears, but a new event in the same cycle survives
    nx.status = ((rd_fire && rd_sel == REG_IRQ_STATUS) ? '0 : st.status) | set;
    nx.pin_q = pins;
    // bus write; software wins over counting in the same cycle
    if (S_AXI_AWVALID && st.awready) begin
      nx.aw_got = 1'b1;
      nx.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      nx.w_got = 1'b1;
      nx.wdata = S_AXI_WDATA;
      nx.wstrb = S_AXI_WSTRB;
    end
    if (st.bvalid && S_AXI_BREADY) begin
      nx.bvalid = 1'b0;
    end
    if (wr_fire) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OKAY;
      case (wr_sel)
        REG_CONTROL: nx.ctrl = wr_merged[CTRL_W-1:0];
        REG_TMR0_COUNT: nx.cnt0 = wr_merged[15:0];
        REG_TMR1_COUNT: nx.cnt1 = wr_merged[15:0];
        REG_TMR2_COUNT: nx.cnt2 = wr_merged[15:0];
        REG_CAP_RELOAD: nx.rcap = wr_merged[15:0];
        REG_IRQ_MASK: nx.mask = wr_merged[IRQ_W-1:0];
        REG_IRQ_STATUS: nx.bresp = RESP_OKAY;
        default: nx.bresp = RESP_SLVERR;
      endcase
    end
    // bus read
    if (st.rvalid && S_AXI_RREADY) begin
      nx.rvalid = 1'b0;
    end
    if (rd_fire) begin
      nx.rvalid = 1'b1;
      nx.rdata = read_word(rd_sel, st);
      nx.rresp = (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    // readies are registered so every bus output comes from a flop
    nx.awready = ~nx.aw_got & ~nx.bvalid;
    nx.wready = ~nx.w_got & ~nx.bvalid;
    nx.arready = ~nx.rvalid;
    nx.irq = |(nx.status & nx.mask);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= STATE_RESET;
    end else begin
      st <= nx;
    end
  end

  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign S_AXI_RVALID = st.rvalid;
  assign IRQ = st.irq;
  assign TMR_ONE_BAUD_TICK = st.baud_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_one_frozen;
    (st.ctrl[CB_TMR1_MODE +: 2] == MODE_SPLIT && !wr_cnt1) |=> $stable(st.cnt1);
  endproperty
  a_one_frozen: assert property (p_one_frozen) else $error("timer one moved in mode 3");

  sequence s_low_wrap;
    split && tick0 && st.cnt0[7:0] == 8'hff && !wr_cnt0;
  endsequence
  property p_low_wrap;
    s_low_wrap |=> st.cnt0[7:0] == 8'h00 && st.status[SB_TMR0_OVF];
  endproperty
  a_low_wrap: assert property (p_low_wrap) else $error("split low byte wrap wrong");

  property p_low_gated;
    (split && st.ctrl[CB_TMR0_GATE] && !EXT_IRQ_PIN_ZERO && !wr_cnt0)
      |=> st.cnt0[7:0] == $past(st.cnt0[7:0]);
  endproperty
  a_low_gated: assert property (p_low_gated) else $error("low byte ignored its gate");

  property p_high_counts;
    (split && st.ctrl[CB_TMR1_RUN] && !wr_cnt0) |=> st.cnt0[15:8] == $past(st.cnt0[15:8]) + 8'h01;
  endproperty
  a_high_counts: assert property (p_high_counts) else $error("high byte not counting");

  property p_one_free;
    (split && st.ctrl[CB_TMR1_MODE +: 2] == MODE_16BIT && !st.ctrl[CB_TMR1_RUN]
      && (!st.ctrl[CB_TMR1_GATE] || EXT_IRQ_PIN_ONE) && (!st.ctrl[CB_TMR1_COUNTER] || fall[1])
      && !wr_cnt1) |=> st.cnt1 == $past(st.cnt1) + 16'h0001;
  endproperty
  a_one_free: assert property (p_one_free) else $error("timer one not running");

  property p_one_gated;
    (split && st.ctrl[CB_TMR1_GATE] && !EXT_IRQ_PIN_ONE && !wr_cnt1) |=> $stable(st.cnt1);
  endproperty
  a_one_gated: assert property (p_one_gated) else $error("timer one ignored its gate");

  property p_no_capture;
    (t2_mode == T2M_CAPTURE && !st.ctrl[CB_EXT_TRIG_EN] && !wr_rcap) |=> $stable(st.rcap);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("capture without enable");

  property p_cap_wrap;
    (t2_mode == T2M_CAPTURE && tick2 && st.cnt2 == 16'hffff && !wr_cnt2)
      |=> st.cnt2 == 16'h0000 && st.status[SB_TMR2_OVF];
  endproperty
  a_cap_wrap: assert property (p_cap_wrap) else $error("capture mode wrap wrong");

  sequence s_cap_trig;
    t2_mode == T2M_CAPTURE && trig && !wr_rcap;
  endsequence
  property p_capture;
    s_cap_trig |=> st.rcap == $past(st.cnt2) && st.status[SB_EXT_TRIG];
  endproperty
  a_capture: assert property (p_capture) else $error("capture not taken");

  property p_reload_wrap;
    (t2_mode == T2M_RELOAD && tick2 && st.cnt2 == 16'hffff && !wr_cnt2 && !wr_rcap)
      |=> st.cnt2 == $past(st.rcap) && st.status[SB_TMR2_OVF];
  endproperty
  a_reload_wrap: assert property (p_reload_wrap) else $error("auto-reload wrong");

  property p_reload_trig;
    (t2_mode == T2M_RELOAD && trig && !wr_cnt2 && !wr_rcap)
      |=> st.cnt2 == $past(st.rcap) && st.status[SB_EXT_TRIG];
  endproperty
  a_reload_trig: assert property (p_reload_trig) else $error("trigger reload wrong");

  property p_baud_quiet;
    (t2_mode == T2M_BAUD && !st.status[SB_TMR2_OVF]) |=> !st.status[SB_TMR2_OVF];
  endproperty
  a_baud_quiet: assert property (p_baud_quiet) else $error("overflow flag in baud mode");

  property p_one_edge;
    (!TMR_TWO_TRIGGER_PIN ##1 !TMR_TWO_TRIGGER_PIN) |-> !fall[3];
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("held-low trigger seen twice");

endmodule : tscr_top
`default_nettype wire

// file: tb/tscr_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module tscr_pin_model (
  // clock
  input wire logic clk,
  // pins toward the block
  output logic [3:0] cnt_pin,
  output logic irq_pin_zero,
  output logic irq_pin_one
);
  // pins rest high, so only a commanded fall can be seen
  initial begin
    cnt_pin = 4'hf;
    irq_pin_zero = 1'b1;
    irq_pin_one = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // two cycles low, two high: a double count would show as a wrong total
  task automatic fall(input int p);
    @(posedge clk);
    cnt_pin[p] <= 1'b0;
    repeat (2) @(posedge clk);
    cnt_pin[p] <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : fall
  task automatic set_gate_zero(input logic v);
    @(posedge clk);
    irq_pin_zero <= v;
  endtask : set_gate_zero
  task automatic set_gate_one(input logic v);
    @(posedge clk);
    irq_pin_one <= v;
  endtask : set_gate_one
endmodule : tscr_pin_model
`default_nettype wire

// file: tb/tscr_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tscr_bench
  import tscr_pkg::*;
;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, gz, g1, baud;
  logic [7:0] awaddr, araddr, m_lo;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, pin, m_stat;
  logic [1:0] bresp, rresp, bresp_q, rresp_q;
  logic [16:0] m_ctrl;
  logic [15:0] m_cnt1, m_cnt2, m_rcap;
  int n_mismatch, cmp_count, cyc, n_baud, m_baud;
  tscr_top dut (
    .CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EXT_IRQ_PIN_ZERO(gz), .EXT_IRQ_PIN_ONE(g1),
    .TMR_ZERO_COUNT_PIN(pin[0]), .TMR_ONE_COUNT_PIN(pin[1]),
    .TMR_TWO_COUNT_PIN(pin[2]), .TMR_TWO_TRIGGER_PIN(pin[3]),
    .IRQ(irq), .TMR_ONE_BAUD_TICK(baud)
  );
  tscr_pin_model pins (.clk(clk), .cnt_pin(pin), .irq_pin_zero(gz), .irq_pin_one(g1));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // a hung handshake must not stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (baud === 1'b1) n_baud <= n_baud + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    case (a)
      OFS_CONTROL: m_ctrl = v[16:0];
      OFS_TMR0_COUNT: m_lo = v[7:0];
      OFS_TMR1_COUNT: m_cnt1 = v[15:0];
      OFS_TMR2_COUNT: m_cnt2 = v[15:0];
      OFS_CAP_RELOAD: m_rcap = v[15:0];
      default: ;
    endcase
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    bresp_q = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    rresp_q = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input string nm, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(nm, v, exp);
    if (a == OFS_IRQ_STATUS) m_stat = 4'h0;
  endtask : rd_chk
  // one pin event, then the model steps as the rules say
  task automatic pulse(input int p);
    logic bd;
    logic co;
    bd = m_ctrl[CB_XMIT_CLK_SEL] | m_ctrl[CB_RECV_CLK_SEL];
    // clock-out mode wraps to zero, never reloads and sets no overflow flag; a trigger still sets its flag
    co = !bd && !m_ctrl[CB_CAP_RELOAD_SEL] && m_ctrl[CB_CLK_OUT_EN];
    pins.fall(p);
    case (p)
      0: begin
        if (!m_ctrl[CB_TMR0_GATE] || gz === 1'b1) begin
          m_lo = m_lo + 8'h1;
          if (m_lo == 8'h0) m_stat[SB_TMR0_OVF] = 1'b1;
        end
      end
      1: begin
        if (m_ctrl[5:4] != MODE_SPLIT && (!m_ctrl[CB_TMR1_GATE] || g1 === 1'b1)) begin
          if (m_ctrl[5:4] == MODE_AUTO8) begin
            if (m_cnt1[7:0] == 8'hff) begin
              m_baud++;
              m_cnt1[7:0] = m_cnt1[15:8];
            end else begin
              m_cnt1[7:0] = m_cnt1[7:0] + 8'h1;
            end
          end else begin
            if (m_cnt1 == 16'hffff) m_baud++;
            m_cnt1 = m_cnt1 + 16'h1;
          end
        end
      end
      2: begin
        if (m_cnt2 == 16'hffff) begin
          m_cnt2 = ((m_ctrl[CB_CAP_RELOAD_SEL] && !bd) || co) ? 16'h0 : m_rcap;
          if (!bd && !co) m_stat[SB_TMR2_OVF] = 1'b1;
        end else begin
          m_cnt2 = m_cnt2 + 16'h1;
        end
      end
      default: begin
        if (m_ctrl[CB_EXT_TRIG_EN]) begin
          m_stat[SB_EXT_TRIG] = 1'b1;
          if (!bd && m_ctrl[CB_CAP_RELOAD_SEL]) m_rcap = m_cnt2;
          else if (!bd && !co) m_cnt2 = m_rcap;
        end
      end
    endcase
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, m_lo, m_stat, m_ctrl, m_cnt1, m_cnt2, m_rcap} = '0;
    wstrb = 4'hf;
    void'($urandom(4648));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(OFS_CONTROL, "control reset", 32'h0);
    rd_chk(OFS_IRQ_MASK, "mask reset", 32'h0);
    rd(8'h1c, d);
    check("unmapped rdata", d, 32'h0);
    check("unmapped rresp", {30'h0, rresp_q}, {30'h0, RESP_SLVERR});
    wr(8'h1c, 32'h5a);
    check("unmapped bresp", {30'h0, bresp_q}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    wr(OFS_TMR1_COUNT, $urandom & 32'h7fff);
    wr(OFS_TMR0_COUNT, 32'hfffe);
    wr(OFS_CONTROL, 32'h337);
    // high byte starts at ff and wraps on its first clock
    m_stat[SB_TMR1_OVF] = 1'b1;
    repeat (3) pulse(0);
    rd(OFS_TMR0_COUNT, d);
    check("split low byte", {24'h0, d[7:0]}, {24'h0, m_lo});
    rd_chk(OFS_IRQ_STATUS, "split flags", {28'h0, m_stat});
    rd_chk(OFS_TMR1_COUNT, "frozen timer one", {16'h0, m_cnt1});
    wr(OFS_CONTROL, 32'h33f);
    pins.set_gate_zero(1'b0);
    pulse(0);
    rd(OFS_TMR0_COUNT, d);
    check("gated low byte", {24'h0, d[7:0]}, {24'h0, m_lo});
    pins.set_gate_zero(1'b1);
    pins.set_gate_one(1'b0);
    wr(OFS_CONTROL, 32'h1d7);
    repeat (2) pulse(1);
    pins.set_gate_one(1'b1);
    repeat (2) pulse(1);
    rd_chk(OFS_TMR1_COUNT, "borrowed timer one", {16'h0, m_cnt1});
    wr(OFS_TMR1_COUNT, {16'h0, 8'($urandom), 8'hfe});
    wr(OFS_CONTROL, 32'h1e7);
    repeat (2) pulse(1);
    rd_chk(OFS_TMR1_COUNT, "borrowed reload", {16'h0, m_cnt1});
    check("baud ticks", n_baud, m_baud);
    rd_chk(OFS_IRQ_STATUS, "borrowed no flag", {28'h0, m_stat});
    $display("test split done");
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_IRQ_STATUS, d);
    m_stat = 4'h0;
    wr(OFS_IRQ_MASK, 32'h8);
    wr(OFS_TMR2_COUNT, 32'hfffe);
    wr(OFS_CONTROL, 32'h1c00);
    pulse(3);
    repeat (3) pulse(2);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_CONTROL, 32'h3c00);
    pulse(3);
    check("irq trigger", {31'h0, irq}, 32'h1);
    rd_chk(OFS_CAP_RELOAD, "capture value", {16'h0, m_rcap});
    rd_chk(OFS_TMR2_COUNT, "capture count", {16'h0, m_cnt2});
    rd_chk(OFS_IRQ_STATUS, "capture flags", {28'h0, m_stat});
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("test capture done");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CAP_RELOAD, {16'h0, 8'h12, 8'($urandom)});
    wr(OFS_TMR2_COUNT, 32'hfffe);
    wr(OFS_CONTROL, 32'h3800);
    repeat (2) pulse(2);
    rd_chk(OFS_TMR2_COUNT, "reload on wrap", {16'h0, m_cnt2});
    pulse(2);
    pulse(3);
    rd_chk(OFS_TMR2_COUNT, "reload on trigger", {16'h0, m_cnt2});
    rd_chk(OFS_IRQ_STATUS, "reload flags", {28'h0, m_stat});
    $display("test reload done");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_TMR2_COUNT, 32'hffff);
    wr(OFS_CONTROL, 32'h7c00);
    pulse(2);
    pulse(3);
    rd_chk(OFS_CAP_RELOAD, "baud no capture", {16'h0, m_rcap});
    rd_chk(OFS_TMR2_COUNT, "baud wrap", {16'h0, m_cnt2});
    rd_chk(OFS_IRQ_STATUS, "baud flags", {28'h0, m_stat});
    $display("test baud done");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_TMR2_COUNT, 32'hffff);
    wr(OFS_CONTROL, 32'h13800);
    pulse(2);
    pulse(3);
    rd_chk(OFS_TMR2_COUNT, "clock-out wrap", {16'h0, m_cnt2});
    rd_chk(OFS_IRQ_STATUS, "clock-out flags", {28'h0, m_stat});
    $display("test clock-out done");
    tally_and_finish();
  end
endmodule : tscr_bench
`default_nettype wire
